// ===== verification/core_model.sv
// Behavioural processor core that takes each offered vector after a chosen delay.
// Assumes the controller's service handshake on the same clock.
`timescale 1ns/1ps
module core_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       svc_req,
    input  wire logic [1:0] dly,
    output logic            entry_ack
);
    logic [1:0] wait_r;
    // The acknowledge rises only while an offer stands; the next edge takes it only if svc_req is still high then.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_ack <= 1'b0;
            wait_r    <= 2'h0;
        end else if (entry_ack) begin
            entry_ack <= 1'b0;
        end else if (svc_req && wait_r >= dly) begin
            entry_ack <= 1'b1;
            wait_r    <= 2'h0;
        end else if (svc_req) begin
            wait_r <= wait_r + 2'h1;
        end
    end
endmodule

// ===== verification/nic_assertions.sv
// Checker of the controller's service handshake, level field and power modes.
// Assumes it is bound to the top module and that everything runs on hclk.
`timescale 1ns/1ps
module nic_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       svc_req,
    input wire logic [3:0] svc_vector,
    input wire logic       entry_ack,
    input wire logic       entry_pulse,
    input wire logic       stack_en,
    input wire logic [7:0] core_condition_flags,
    input wire logic       instr_valid,
    input wire logic [2:0] instr_op,
    input wire logic [7:0] pop_cc,
    input wire logic [2:0] power_mode,
    input wire logic       wake_pulse
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [1:0] lvl;
    logic       tk;
    assign lvl = {core_condition_flags[5], core_condition_flags[3]};
    // An acknowledge in the same cycle outranks an instruction, so those cycles are left out.
    assign tk  = svc_req && entry_ack;
    a_entry_taken: assert property (tk |=> entry_pulse && !svc_req) else $error("entry not signalled");
    a_reset_entry: assert property (tk && svc_vector == 4'hF |=> !stack_en && lvl == 2'h3) else $error("bad reset entry");
    a_nmi_entry: assert property (tk && svc_vector inside {4'h0, 4'hE} |=> stack_en && lvl == 2'h3) else $error("bad nmi entry");
    a_unmask_level: assert property (instr_valid && instr_op == 3'h0 && !tk |=> lvl == 2'h2) else $error("unmask level");
    a_mask_level: assert property (instr_valid && instr_op == 3'h1 && !tk |=> lvl == 2'h3) else $error("mask level");
    a_return_flags: assert property (instr_valid && instr_op == 3'h4 && !tk |=> core_condition_flags == $past(pop_cc))
        else $error("return flags");
    a_stop_mode: assert property (instr_valid && instr_op == 3'h2 && !tk |=> power_mode == 3'h4) else $error("stop mode");
    a_idle_noreq: assert property (power_mode != 3'h1 |-> !svc_req) else $error("offer while idle");
    a_wake_run: assert property (wake_pulse |-> power_mode == 3'h1 && $past(power_mode) != 3'h1) else $error("wake");
    a_mask_blocks: assert property (tk && svc_vector inside {[4'h1:4'hD]} |-> lvl != 2'h3) else $error("masked served");
    c_trap: cover property (tk && svc_vector == 4'hE);
    c_wake: cover property (wake_pulse);
    c_nest: cover property (tk && svc_vector == 4'h9);
endmodule

bind nested_priority_interrupt_controller nic_checker nic_checker_inst (.hclk, .hresetn, .svc_req, .svc_vector,
    .entry_ack, .entry_pulse, .stack_en, .core_condition_flags, .instr_valid, .instr_op, .pop_cc, .power_mode,
    .wake_pulse);

// ===== verification/testbench.sv
// Self-checking bench for the nested priority interrupt controller.
// Assumes the core model and the bound checker are compiled before it.
`timescale 1ns/1ps
module testbench;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, tlp, instr_valid, entry_ack, svc_req, entry_pulse;
    logic        stack_en, wake_pulse, rdy;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, dly;
    logic [2:0]  instr_op, power_mode;
    logic [3:0]  svc_vector, tv;
    logic [7:0]  pop_cc, flags;
    logic [13:0] pf, pe, pc;
    logic [15:0] ext_pins;
    logic [7:0]  q[$];
    int          num_errors, total_checks, seed;

    nested_priority_interrupt_controller nested_priority_interrupt_controller_inst (.hclk, .hresetn, .ce(1'b1),
        .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp(),
        .top_level_pin_request(tlp), .ext_pins, .periph_flag(pf), .periph_en(pe), .periph_clear(pc), .instr_valid,
        .instr_op, .pop_cc, .entry_ack, .svc_req, .svc_vector, .entry_pulse, .stack_cc(), .stack_en, .wake_pulse,
        .core_condition_flags(flags), .power_mode);
    core_model core_model_inst (.hclk, .hresetn, .svc_req, .dly, .entry_ack);

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude();
        if (q.size() != 0) chk(8'h0, 8'h1, "missing entry");
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Values seen half a cycle before an edge are what that edge samples, free of update races.
    always @(negedge hclk) begin
        rdy = hreadyout;
        rd = hrdata;
        if (entry_pulse && q.size() == 0) chk(8'h0, 8'h1, "extra entry");
        else if (entry_pulse) chk({tv, flags[5], flags[3], 1'b0, stack_en}, q.pop_front(), "entry");
        if (svc_req && entry_ack) tv = svc_vector;
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [7:0] exp);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (!rdy);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!rdy);
        if (!w) chk(rd[7:0], exp, "reg");
    endtask

    task automatic ins(input logic [2:0] op);
        @(posedge hclk);
        instr_valid <= 1'b1;
        instr_op <= op;
        pop_cc <= 8'($random(seed)) & 8'hD7 | 8'h20;
        dly <= 2'($random(seed));
        @(posedge hclk);
        instr_valid <= 1'b0;
    endtask

    // Peripheral flags stay set until a clear sequence; the flag itself drops one cycle after the clear.
    task automatic pls(input logic [13:0] f, input logic [13:0] c);
        @(posedge hclk);
        pf <= pf | f;
        pc <= c;
        @(posedge hclk);
        pf <= pf & ~c;
        pc <= 14'h0;
    endtask

    task automatic went();
        do @(negedge hclk); while (!entry_pulse);
    endtask

    initial begin
        {hsel, hwrite, instr_valid, haddr, htrans, hwdata, pf, pe, pc, instr_op, pop_cc, dly, hresetn} = '0;
        tlp = 1'b1;
        ext_pins = '1;
        seed = 49061;
        q.push_back(8'hFC);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h00, 32'h0, 8'hEA);
        bus(1'b0, 8'h04, 32'h0, 8'hFF);
        bus(1'b1, 8'h08, 32'hCF, 8'h0);
        bus(1'b1, 8'h08, 32'h64, 8'h0);
        bus(1'b0, 8'h08, 32'h0, 8'h44);
        bus(1'b1, 8'h0C, 32'h01, 8'h0);
        bus(1'b1, 8'h10, 32'h0C, 8'h0);
        bus(1'b0, 8'h10, 32'h0, 8'hFC);
        $display("registers done");
        pe <= 14'h1700;
        pls(14'h1F00, 14'h0);
        pls(14'h0, 14'h0400);
        q.push_back({4'h9, 4'h1});
        q.push_back({4'hC, 4'h1});
        q.push_back({4'h8, 4'h5});
        ins(3'h0);
        repeat (3) begin
            went();
            pls(14'h0, 14'h1 << tv);
            ins(3'h4);
        end
        $display("arbitration done");
        ins(3'h1);
        q.push_back({4'hE, 4'hD});
        q.push_back({4'h0, 4'hD});
        ins(3'h6);
        went();
        @(posedge hclk);
        tlp <= 1'b0;
        went();
        $display("nmi done");
        bus(1'b1, 8'h04, 32'hDF, 8'h0);
        bus(1'b1, 8'h18, 32'h1, 8'h0);
        pls(14'h0200, 14'h0);
        q.push_back({4'h2, 4'h5});
        q.push_back({4'h9, 4'h1});
        ins(3'h2);
        ext_pins[0] <= 1'b0;
        went();
        went();
        pls(14'h0, 14'h0200);
        ins(3'h3);
        q.push_back({4'hC, 4'h1});
        pls(14'h1000, 14'h0);
        went();
        repeat (10) @(posedge hclk);
        $display("wake done");
        conclude();
    end

    // About 150 cycles are expected; the limit leaves a wide margin.
    initial begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: timeout", $time);
        conclude();
    end
endmodule

// ===== verilog/nested_priority_interrupt_controller.sv
// Nested priority interrupt controller with an AHB-Lite register slave.
// Assumes the core, peripherals and bus master run on hclk; only the pins are asynchronous.
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
module nested_priority_interrupt_controller
    import nic_pkg::*;
#(
    parameter int                N_VEC       = 14,
    parameter int                EXT_GROUPS  = 4,
    parameter int                GROUP_PINS  = 4,
    parameter logic [N_VEC-1:0]  WAKE_MASK   = `CFG_WAKE_MASK,
    parameter logic [N_VEC-1:0]  PERIPH_MASK = `CFG_PERIPH_MASK
)(
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          ce,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic      [31:0]                   hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic                          top_level_pin_request,
    input  wire logic [EXT_GROUPS*GROUP_PINS-1:0] ext_pins,
    input  wire logic [N_VEC-1:0]              periph_flag,
    input  wire logic [N_VEC-1:0]              periph_en,
    input  wire logic [N_VEC-1:0]              periph_clear,
    input  wire logic                          instr_valid,
    input  wire logic [2:0]                    instr_op,
    input  wire logic [7:0]                    pop_cc,
    input  wire logic                          entry_ack,
    output logic                               svc_req,
    output logic      [3:0]                    svc_vector,
    output logic                               entry_pulse,
    output logic      [7:0]                    stack_cc,
    output logic                               stack_en,
    output logic                               wake_pulse,
    output logic      [7:0]                    core_condition_flags,
    output logic      [2:0]                    power_mode
);
    localparam int NPINS = EXT_GROUPS * GROUP_PINS;

    // Register state.
    logic [7:0]        cc_r;
    logic [8:0]        sense_r;
    logic [NPINS-1:0]  select_r;
    logic [N_VEC-1:0]  pend_r;
    logic [N_VEC-1:0]  pend_nxt;
    logic              trap_pend_r;
    logic              rst_pend_r;
    logic              stop_exit_r;
    power_mode_e       st_r;

    // Bus slave state.
    logic              ph_wr_r;
    logic              ph_ok_r;
    logic [7:0]        ph_addr_r;
    logic [1:0]        rd_stage_r;
    logic [7:0]        prio_rd;
    logic [8*`CFG_PRIO_REGS-1:0] all_pairs;

    // Pin synchronisers; stage three only remembers the previous settled value.
    logic              tli_s1_r, tli_s2_r, tli_s3_r;
    logic [NPINS-1:0]  ext_s1_r, ext_s2_r, ext_s3_r;

    logic              take;
    logic              bus_wr;
    logic [7:0]        prio_off;
    logic              prio_hit;
    logic              tli_evt;
    logic [N_VEC-1:0]  grp_evt;
    logic [N_VEC-1:0]  cand;
    logic              wake_filter;
    logic [1:0]        cur_rank;
    logic              best_ok;
    logic [2:0]        best_rank;
    logic [3:0]        best_idx;
    logic              sel_valid;
    logic [3:0]        sel_vec;
    logic              ack;
    logic [1:0]        ack_pair;
    logic              instr_trap;

    assign take      = hsel & hready & (htrans == `CFG_HTRANS_NONSEQ);
    assign bus_wr    = ph_wr_r & ph_ok_r & hready;
    assign prio_off  = ph_addr_r - `CFG_OFF_PRIO0;
    assign prio_hit  = (ph_addr_r >= `CFG_OFF_PRIO0) && (ph_addr_r <= `CFG_OFF_PRIO3);
    assign ack       = entry_ack & svc_req;
    assign ack_pair  = all_pairs[{svc_vector, 1'b0} +: 2];
    assign instr_trap = instr_valid && (instr_op == `CFG_OP_TRAP);

    prio_store #(
        .N_REGS    (`CFG_PRIO_REGS)
    ) u_prio (
        .clk       (hclk),
        .rstn      (hresetn),
        .ce        (ce),
        .wr_en     (bus_wr && prio_hit),
        .wr_idx    (prio_off[3:2]),
        .wr_data   (hwdata[7:0]),
        .rd_en     (rd_stage_r == 2'h1),
        .rd_idx    (prio_off[3:2]),
        .rd_data_r (prio_rd),
        .all_pairs (all_pairs)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tli_s1_r <= 1'b1;
            tli_s2_r <= 1'b1;
            tli_s3_r <= 1'b1;
            ext_s1_r <= '1;
            ext_s2_r <= '1;
            ext_s3_r <= '1;
        end else if (ce) begin
            tli_s1_r <= top_level_pin_request;
            tli_s2_r <= tli_s1_r;
            tli_s3_r <= tli_s2_r;
            ext_s1_r <= ext_pins;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    // Pin event detection per group, with every selected pin ORed onto the group line.
    always_comb begin
        logic cur;
        logic prv;
        logic hit;
        cur = 1'b0;
        prv = 1'b0;
        hit = 1'b0;
        grp_evt = '0;
        tli_evt = sense_r[`CFG_SENSE_TLI_BIT] ? (tli_s2_r & ~tli_s3_r) : (~tli_s2_r & tli_s3_r);
        for (int g = 0; g < EXT_GROUPS; g++) begin
            for (int p = 0; p < GROUP_PINS; p++) begin
                cur = ext_s2_r[g*GROUP_PINS + p];
                prv = ext_s3_r[g*GROUP_PINS + p];
                case (sense_r[2*g +: 2])
                    `CFG_SENSE_FALL: hit = prv & ~cur;
                    `CFG_SENSE_RISE: hit = ~prv & cur;
                    `CFG_SENSE_BOTH: hit = prv ^ cur;
                    default:         hit = ~cur;
                endcase
                if (select_r[g*GROUP_PINS + p] && hit) begin
                    grp_evt[`CFG_EXT_BASE + g] = 1'b1;
                end
            end
        end
    end

    // Request latches: pin edges hold until entry, peripheral requests follow flag and enable.
    always_comb begin
        pend_nxt = '0;
        for (int i = 0; i < N_VEC; i++) begin
            if (PERIPH_MASK[i]) begin
                pend_nxt[i] = periph_flag[i] & periph_en[i] & ~periph_clear[i];
            end else if (i == 0) begin
                pend_nxt[i] = tli_evt | (pend_r[i] & ~(ack && svc_vector == `CFG_VEC_TLI));
            end else if (i >= `CFG_EXT_BASE && i < `CFG_EXT_BASE + EXT_GROUPS) begin
                pend_nxt[i] = grp_evt[i] | (pend_r[i] & ~(ack && svc_vector == 4'(i)));
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= '0;
        end else if (ce) begin
            pend_r <= pend_nxt;
        end
    end

    // Arbitration: rank first, then the lower index; the top pin ranks above level 3.
    always_comb begin
        logic [2:0] r;
        r = 3'h0;
        cur_rank    = rank_of(level_of(cc_r));
        wake_filter = stop_exit_r | (st_r == pm_stop);
        best_ok     = 1'b0;
        best_rank   = 3'h0;
        best_idx    = 4'h0;
        for (int i = N_VEC - 1; i >= 0; i--) begin
            r = (i == 0) ? 3'h4 : {1'b0, rank_of(all_pairs[2*i +: 2])};
            cand[i] = pend_r[i] && ((i == 0) || (r > {1'b0, cur_rank}))
                      && (!wake_filter || WAKE_MASK[i]);
            if (cand[i] && (!best_ok || r >= best_rank)) begin
                best_ok   = 1'b1;
                best_rank = r;
                best_idx  = 4'(i);
            end
        end
        sel_valid = rst_pend_r | trap_pend_r | best_ok;
        if (rst_pend_r) begin
            sel_vec = `CFG_VEC_RESET;
        end else if (trap_pend_r) begin
            sel_vec = `CFG_VEC_TRAP;
        end else begin
            sel_vec = best_idx;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_pend_r  <= 1'b1;
            trap_pend_r <= 1'b0;
        end else if (ce) begin
            if (ack && svc_vector == `CFG_VEC_RESET) begin
                rst_pend_r <= 1'b0;
            end
            if (instr_trap) begin
                trap_pend_r <= 1'b1;
            end else if (ack && svc_vector == `CFG_VEC_TRAP) begin
                trap_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_req    <= 1'b0;
            svc_vector <= 4'h0;
        end else if (ce) begin
            // Dropped for one cycle after an entry so the new level takes part in the next choice.
            // Also held low as a stop or sleep is taken, since the core answers no offer while idle.
            svc_req    <= sel_valid && (st_r == pm_run) && !ack
                          && !(instr_valid && (instr_op == `CFG_OP_STOP || instr_op == `CFG_OP_SLEEP));
            svc_vector <= sel_vec;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= pm_run;
            stop_exit_r <= 1'b0;
            wake_pulse  <= 1'b0;
        end else if (ce) begin
            wake_pulse <= 1'b0;
            if (ack) begin
                stop_exit_r <= 1'b0;
            end
            case (st_r)
                pm_run: begin
                    if (instr_valid && instr_op == `CFG_OP_STOP) begin
                        st_r <= pm_stop;
                    end else if (instr_valid && instr_op == `CFG_OP_SLEEP) begin
                        st_r <= pm_sleep;
                    end
                end
                pm_sleep: begin
                    if (sel_valid) begin
                        st_r       <= pm_run;
                        wake_pulse <= 1'b1;
                    end
                end
                pm_stop: begin
                    if (sel_valid) begin
                        st_r        <= pm_run;
                        stop_exit_r <= 1'b1;
                        wake_pulse  <= 1'b1;
                    end
                end
                default: st_r <= pm_run;
            endcase
        end
    end

    // Condition flags: entry beats an instruction, which beats a bus write.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cc_r        <= `CFG_CC_RESET;
            stack_cc    <= 8'h00;
            stack_en    <= 1'b0;
            entry_pulse <= 1'b0;
        end else if (ce) begin
            entry_pulse <= ack;
            if (ack) begin
                stack_cc <= cc_r;
                stack_en <= (svc_vector != `CFG_VEC_RESET);
                if (svc_vector == `CFG_VEC_RESET || svc_vector == `CFG_VEC_TRAP
                    || svc_vector == `CFG_VEC_TLI) begin
                    cc_r <= set_level(cc_r, `CFG_PAIR_L3);
                end else begin
                    cc_r <= set_level(cc_r, ack_pair);
                end
            end else if (instr_valid) begin
                case (instr_op)
                    `CFG_OP_UNMASK: cc_r <= set_level(cc_r, `CFG_PAIR_L0);
                    `CFG_OP_MASK:   cc_r <= set_level(cc_r, `CFG_PAIR_L3);
                    `CFG_OP_STOP:   cc_r <= set_level(cc_r, `CFG_PAIR_L0);
                    `CFG_OP_SLEEP:  cc_r <= set_level(cc_r, `CFG_PAIR_L0);
                    `CFG_OP_RETURN: cc_r <= pop_cc;
                    `CFG_OP_POP_CC: cc_r <= pop_cc;
                    default:        cc_r <= cc_r;
                endcase
            end else if (bus_wr && ph_addr_r == `CFG_OFF_CFLAGS) begin
                cc_r <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sense_r  <= `CFG_SENSE_RESET;
            select_r <= `CFG_SELECT_RESET;
        end else if (ce && bus_wr) begin
            if (ph_addr_r == `CFG_OFF_SENSE) begin
                sense_r <= hwdata[8:0];
            end
            if (ph_addr_r == `CFG_OFF_SELECT) begin
                select_r <= hwdata[NPINS-1:0];
            end
        end
    end

    // Bus slave: writes finish with no wait state; reads wait two cycles for the store's read register.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr_r    <= 1'b0;
            ph_ok_r    <= 1'b0;
            ph_addr_r  <= 8'h00;
            rd_stage_r <= 2'h0;
            hreadyout  <= 1'b1;
            hresp      <= `CFG_HRESP_OKAY;
            hrdata     <= 32'h0000_0000;
        end else if (ce) begin
            hresp <= `CFG_HRESP_OKAY;
            if (rd_stage_r == 2'h1) begin
                rd_stage_r <= 2'h2;
            end else if (rd_stage_r == 2'h2) begin
                rd_stage_r <= 2'h0;
                hreadyout  <= 1'b1;
                if (!ph_ok_r) begin
                    hrdata <= 32'h0000_0000;
                end else if (prio_hit) begin
                    hrdata <= {24'h00_0000, prio_rd};
                end else begin
                    case (ph_addr_r)
                        `CFG_OFF_CFLAGS: hrdata <= {24'h00_0000, cc_r};
                        `CFG_OFF_SENSE:  hrdata <= 32'(sense_r);
                        `CFG_OFF_SELECT: hrdata <= 32'(select_r);
                        `CFG_OFF_STATUS: hrdata <= 32'({stop_exit_r, st_r, trap_pend_r, pend_r});
                        default:         hrdata <= 32'h0000_0000;
                    endcase
                end
            end else if (hready) begin
                ph_wr_r <= take & hwrite;
                if (take) begin
                    ph_addr_r <= haddr[7:0];
                    ph_ok_r   <= (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
                    if (!hwrite) begin
                        rd_stage_r <= 2'h1;
                        hreadyout  <= 1'b0;
                    end
                end
            end
        end
    end

    assign core_condition_flags = cc_r;
    assign power_mode           = st_r;
endmodule

// ===== verilog/nic_cfg.svh
// Constants for the nested priority interrupt controller: offsets, encodings, reset values.
// Assumes it is included once, through the package, before any module that uses it.
`ifndef NIC_CFG_SVH
`define NIC_CFG_SVH

// Priority pair encodings {upper, lower}, as stored in the condition flags and per vector.
`define CFG_PAIR_L0       2'h2
`define CFG_PAIR_L1       2'h1
`define CFG_PAIR_L2       2'h0
`define CFG_PAIR_L3       2'h3
`define CFG_CC_HI_BIT     5
`define CFG_CC_LO_BIT     3
`define CFG_CC_RESET      8'hEA
`define CFG_PRIO_RESET    8'hFF
`define CFG_PRIO3_RO_MASK 8'hF0

// Register byte offsets on the bus.
`define CFG_OFF_CFLAGS    8'h00
`define CFG_OFF_PRIO0     8'h04
`define CFG_OFF_PRIO3     8'h10
`define CFG_OFF_SENSE     8'h14
`define CFG_OFF_SELECT    8'h18
`define CFG_OFF_STATUS    8'h1C
`define CFG_PRIO_REGS     4

// Service vector codes.
`define CFG_VEC_TLI       4'h0
`define CFG_VEC_TRAP      4'hE
`define CFG_VEC_RESET     4'hF

// Core instruction codes.
`define CFG_OP_UNMASK     3'h0
`define CFG_OP_MASK       3'h1
`define CFG_OP_STOP       3'h2
`define CFG_OP_SLEEP      3'h3
`define CFG_OP_RETURN     3'h4
`define CFG_OP_POP_CC     3'h5
`define CFG_OP_TRAP       3'h6

// External pin sensitivity codes.
`define CFG_SENSE_FALL    2'h0
`define CFG_SENSE_RISE    2'h1
`define CFG_SENSE_BOTH    2'h2
`define CFG_SENSE_FALLLOW 2'h3
`define CFG_SENSE_RESET   9'h000
`define CFG_SELECT_RESET  16'h0000
`define CFG_SENSE_TLI_BIT 8

// Vector roles.
`define CFG_WAKE_MASK     14'h20BF
`define CFG_PERIPH_MASK   14'h3F82
`define CFG_EXT_BASE      2

`define CFG_HTRANS_NONSEQ 2'h2
`define CFG_HRESP_OKAY    1'h0

`endif

// ===== verilog/nic_pkg.sv
// Types and small helper functions of the nested priority interrupt controller.
// Assumes nic_cfg.svh sits beside it on the include path.
package nic_pkg;
`include "nic_cfg.svh"

    typedef enum logic [2:0] {
        pm_run   = 3'h1,
        pm_sleep = 3'h2,
        pm_stop  = 3'h4
    } power_mode_e;

    // Numeric rank 0..3 of a priority pair, so that plain comparison orders levels.
    function automatic logic [1:0] rank_of(input logic [1:0] pair);
        case (pair)
            `CFG_PAIR_L0: rank_of = 2'h0;
            `CFG_PAIR_L1: rank_of = 2'h1;
            `CFG_PAIR_L2: rank_of = 2'h2;
            default:      rank_of = 2'h3;
        endcase
    endfunction

    function automatic logic [7:0] set_level(input logic [7:0] cc, input logic [1:0] pair);
        logic [7:0] r;
        r = cc;
        r[`CFG_CC_HI_BIT] = pair[1];
        r[`CFG_CC_LO_BIT] = pair[0];
        set_level = r;
    endfunction

    function automatic logic [1:0] level_of(input logic [7:0] cc);
        level_of = {cc[`CFG_CC_HI_BIT], cc[`CFG_CC_LO_BIT]};
    endfunction
endpackage

// ===== verilog/prio_store.sv
// Per-vector priority register file: byte registers of four two-bit pairs each.
// Assumes one write and one read request at most per cycle, both from the bus slave.
`timescale 1ns/1ps
module prio_store
    import nic_pkg::*;
#(
    parameter int N_REGS = `CFG_PRIO_REGS
)(
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    ce,
    input  wire logic                    wr_en,
    input  wire logic [1:0]              wr_idx,
    input  wire logic [7:0]              wr_data,
    input  wire logic                    rd_en,
    input  wire logic [1:0]              rd_idx,
    output logic      [7:0]              rd_data_r,
    output logic      [8*N_REGS-1:0]     all_pairs
);
    logic [7:0] mem_r [N_REGS];

    always_comb begin
        for (int i = 0; i < N_REGS; i++) begin
            all_pairs[8*i +: 8] = mem_r[i];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N_REGS; i++) begin
                mem_r[i] <= `CFG_PRIO_RESET;
            end
        end else if (ce && wr_en) begin
            for (int p = 0; p < 4; p++) begin
                // The level 0 code is not storable; such a pair keeps its old value.
                if (wr_data[2*p +: 2] != `CFG_PAIR_L0) begin
                    mem_r[wr_idx][2*p +: 2] <= wr_data[2*p +: 2];
                end
            end
            if (int'(wr_idx) == N_REGS - 1) begin
                mem_r[wr_idx] <= (mem_r[wr_idx] & `CFG_PRIO3_RO_MASK) | (`CFG_PRIO3_RO_MASK & `CFG_PRIO_RESET)
                                 | (merge_pairs(mem_r[wr_idx], wr_data) & ~`CFG_PRIO3_RO_MASK);
            end
        end
    end

    function automatic logic [7:0] merge_pairs(input logic [7:0] old_v, input logic [7:0] new_v);
        logic [7:0] r;
        r = old_v;
        for (int p = 0; p < 4; p++) begin
            if (new_v[2*p +: 2] != `CFG_PAIR_L0) begin
                r[2*p +: 2] = new_v[2*p +: 2];
            end
        end
        merge_pairs = r;
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_r <= 8'h00;
        end else if (ce && rd_en) begin
            rd_data_r <= mem_r[rd_idx];
        end
    end
endmodule
